// ===== rtl/isrt_host.sv
// controller that drives the serial bus unit through stop and restart
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
module isrt_host
  import isrt_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_out,
  // control register write port of the device
  output logic dev_wr_out,
  output logic dev_master_select_out,
  output logic dev_transmit_select_out,
  output logic dev_service_request_out,
  output logic dev_bus_busy_out,
  // status read back from the device
  input wire logic dev_bus_busy_in,
  input wire logic dev_last_received_bit_in,
  // bus lines, clock line open drain
  input wire logic clock_line_pin_in,
  input wire logic data_line_pin_in,
  output logic clock_line_pin_out,
  output logic clock_line_pin_oe_out
);

  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  logic [3:0] sync_q;
  logic bb_s;
  logic lrb_s;
  logic scl_s;
  logic sda_s;
  logic sda_prev;
  logic stop_seen;

  isrt_sync #(.W(4)) u_sync (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .d_in({dev_bus_busy_in, dev_last_received_bit_in,
           clock_line_pin_in, data_line_pin_in}),
    .q_out(sync_q)
  );

  assign bb_s = sync_q[3];
  assign lrb_s = sync_q[2];
  assign scl_s = sync_q[1];
  assign sda_s = sync_q[0];

  // data rising while clock high marks a stop on the bus
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
      sda_prev <= 1'b1;
    else
      sda_prev <= sda_s;
  end

  assign stop_seen = scl_s && sda_s && !sda_prev;

  // ****************************************************************
  // register file
  // ****************************************************************
  logic fast_mode;
  logic rx_mode;
  logic [EV_W-1:0] int_status;
  logic [EV_W-1:0] int_mask;
  logic [7:0] stretch_len;
  logic [EV_W-1:0] ev_set;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic cmd_stop;
  logic cmd_restart;
  logic cmd_stretch;
  isrt_state_t state;
  logic stretching;

  // zero wait state slave
  assign pready = 1'b1;
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                  (paddr == REG_INT_STATUS) ||
                  (paddr == REG_INT_MASK) ||
                  (paddr == REG_STRETCH_LEN);
  assign pslverr = acc && !mapped;

  assign cmd_stop = wr_acc && (paddr == REG_CTRL) &&
                    pwdata[CTRL_STOP_BIT];
  assign cmd_restart = wr_acc && (paddr == REG_CTRL) &&
                       pwdata[CTRL_RESTART_BIT];
  assign cmd_stretch = wr_acc && (paddr == REG_CTRL) &&
                       pwdata[CTRL_STRETCH_BIT];

  // mode bits and stretch length
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      fast_mode <= 1'b0;
      rx_mode <= 1'b0;
      int_mask <= INT_MASK_RESET;
      stretch_len <= STRETCH_LEN_RESET;
    end
    else if (wr_acc)
    begin
      if (paddr == REG_CTRL)
      begin
        fast_mode <= pwdata[CTRL_FAST_BIT];
        rx_mode <= pwdata[CTRL_RX_BIT];
      end
      if (paddr == REG_INT_MASK)
        int_mask <= pwdata[EV_W-1:0];
      if (paddr == REG_STRETCH_LEN)
        stretch_len <= pwdata[7:0];
    end
  end

  // sticky events; a read clears, but a new event wins
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
      int_status <= '0;
    else if (rd_acc && (paddr == REG_INT_STATUS))
      int_status <= ev_set;
    else
      int_status <= int_status | ev_set;
  end

  assign irq_out = |(int_status & int_mask);

  // read data registered one cycle early is not possible at zero wait,
  // so the mux is taken straight from flip-flop state
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_acc)
    begin
      unique case (paddr)
        REG_CTRL:
          prdata = {27'h0, 1'b0, rx_mode, fast_mode, 2'b00};
        REG_STATUS:
          prdata = {24'h0, stretching, state != ST_IDLE,
                    2'b00, bb_s, lrb_s, scl_s, sda_s};
        REG_INT_STATUS:
          prdata = {28'h0, int_status};
        REG_INT_MASK:
          prdata = {28'h0, int_mask};
        REG_STRETCH_LEN:
          prdata = {24'h0, stretch_len};
        default:
          prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // stop and restart sequencer
  // ****************************************************************
  logic [7:0] cnt;
  logic [7:0] su_cyc;
  logic [7:0] buf_cyc;
  logic bus_free;

  assign su_cyc = fast_mode ? 8'(SU_FAST_CYC) : 8'(SU_STD_CYC);
  assign buf_cyc = fast_mode ? 8'(BUF_FAST_CYC) : 8'(BUF_STD_CYC);

  assign bus_free = rx_mode ? scl_s : lrb_s;

  // state and shared wait counter
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      state <= ST_IDLE;
      cnt <= 8'h00;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          cnt <= 8'h00;
          if (cmd_stop && bb_s)
            state <= ST_STOP_WAIT;
          else if (cmd_restart && !cmd_stop)
            state <= ST_RS_BB;
        end
        ST_STOP_WAIT:
        begin
          if (stop_seen || (!bb_s && sda_s && scl_s))
            state <= ST_BUF;
        end
        ST_BUF:
        begin
          if (cnt >= buf_cyc - 8'h01)
            state <= ST_IDLE;
          else
            cnt <= cnt + 8'h01;
        end
        ST_RS_BB:
        begin
          if (!bb_s)
            state <= ST_RS_LRB;
        end
        ST_RS_LRB:
        begin
          if (bus_free)
            state <= ST_RS_SU;
        end
        ST_RS_SU:
        begin
          if (!bus_free)
          begin
            state <= ST_RS_LRB;
            cnt <= 8'h00;
          end
          else if (cnt >= su_cyc - 8'h01)
            state <= ST_IDLE;
          else
            cnt <= cnt + 8'h01;
        end
      endcase
    end
  end

  // device control word; held between commands
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      dev_wr_out <= 1'b0;
      dev_master_select_out <= 1'b0;
      dev_transmit_select_out <= 1'b0;
      dev_service_request_out <= 1'b0;
      dev_bus_busy_out <= 1'b0;
    end
    else
    begin
      dev_wr_out <= 1'b0;
      if (state == ST_IDLE)
      begin
        if (cmd_stop && bb_s)
        begin
          dev_wr_out <= 1'b1;
          dev_master_select_out <= 1'b1;
          dev_transmit_select_out <= 1'b1;
          dev_service_request_out <= 1'b1;
          dev_bus_busy_out <= 1'b0;
        end
        else if (cmd_restart && !cmd_stop)
        begin
          dev_wr_out <= 1'b1;
          dev_master_select_out <= 1'b0;
          dev_transmit_select_out <= 1'b0;
          dev_service_request_out <= 1'b1;
          dev_bus_busy_out <= 1'b0;
        end
      end
      // word is not touched until the next command accepted in idle
    end
  end

  // events raised by the sequencer
  always_comb
  begin
    ev_set = '0;
    ev_set[EV_STOP_DONE] = (state == ST_BUF) &&
                           (cnt >= buf_cyc - 8'h01);
    ev_set[EV_RESTART_READY] = (state == ST_RS_SU) && bus_free &&
                               (cnt >= su_cyc - 8'h01);
    ev_set[EV_REFUSED] = (cmd_stop && (state != ST_IDLE || !bb_s)) ||
                         (cmd_restart && (state != ST_IDLE || cmd_stop)) ||
                         (cmd_stretch && stretching);
    // restart must not show a stop
    ev_set[EV_UNEXPECTED_STOP] = stop_seen &&
      ((state == ST_RS_BB) || (state == ST_RS_LRB) ||
       (state == ST_RS_SU));
  end

  // ****************************************************************
  // clock stretching on the shared clock line
  // ****************************************************************
  logic [7:0] st_cnt;
  logic [7:0] hi_cnt;
  logic [7:0] low_len;

  // never shorter than the device can sample
  assign low_len = (stretch_len < STRETCH_LOW_MIN) ?
                   STRETCH_LOW_MIN : stretch_len;

  // high time counted so a new stretch keeps the high minimum
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
      hi_cnt <= 8'h00;
    else if (!scl_s || stretching)
      hi_cnt <= 8'h00;
    else if (hi_cnt < STRETCH_HIGH_MIN)
      hi_cnt <= hi_cnt + 8'h01;
  end

  // hold the line low for low_len cycles after a stretch command
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      stretching <= 1'b0;
      st_cnt <= 8'h00;
    end
    else if (stretching)
    begin
      if (st_cnt >= low_len - 8'h01)
        stretching <= 1'b0;
      else
        st_cnt <= st_cnt + 8'h01;
    end
    else if (cmd_stretch && (hi_cnt >= STRETCH_HIGH_MIN || !scl_s))
    begin
      stretching <= 1'b1;
      st_cnt <= 8'h00;
    end
  end

  // open drain: drive low only
  assign clock_line_pin_out = 1'b0;
  assign clock_line_pin_oe_out = stretching;

endmodule // isrt_host

// ===== rtl/isrt_pkg.sv
// constants and types for the stop and restart sequencing controller
// Functional notes
// - stop: set select, transmit, request; clear busy
// - hold stop control bits until stop seen
// - restart: clear select, transmit, busy; set request
// - poll busy status until it reads zero
// - poll last bit until one, then start
// - wait 4.7 us standard, 0.6 us fast
// - receiver mode: check clock pin, not last bit
// - stretched clock low 5, high 3 cycles
// - the controller times bus free and restart setup
// - choose standard or fast mode per clock
package isrt_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_SU_STA_STD_NS = 4700;
  localparam int T_SU_STA_FAST_NS = 600;
  localparam int T_BUF_STD_NS = 4700;
  localparam int T_BUF_FAST_NS = 1300;
  // least times round up to whole cycles
  localparam int SU_STD_CYC =
    (T_SU_STA_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SU_FAST_CYC =
    (T_SU_STA_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUF_STD_CYC =
    (T_BUF_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUF_FAST_CYC =
    (T_BUF_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // external clock low and high minima in gear cycles
  localparam logic [7:0] STRETCH_LOW_MIN = 8'h05;
  localparam logic [7:0] STRETCH_HIGH_MIN = 8'h03;
  localparam logic [7:0] STRETCH_LEN_RESET = 8'h05;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0C;
  localparam logic [7:0] REG_STRETCH_LEN = 8'h10;
  // control fields
  localparam int CTRL_STOP_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int CTRL_FAST_BIT = 2;
  localparam int CTRL_RX_BIT = 3;
  localparam int CTRL_STRETCH_BIT = 4;
  // event fields
  localparam int EV_STOP_DONE = 0;
  localparam int EV_RESTART_READY = 1;
  localparam int EV_REFUSED = 2;
  localparam int EV_UNEXPECTED_STOP = 3;
  localparam int EV_W = 4;
  localparam logic [EV_W-1:0] INT_MASK_RESET = 4'h0;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_STOP_WAIT = 6'b000010,
    ST_BUF = 6'b000100,
    ST_RS_BB = 6'b001000,
    ST_RS_LRB = 6'b010000,
    ST_RS_SU = 6'b100000
  } isrt_state_t;

endpackage

// ===== rtl/isrt_sync.sv
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module isrt_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      meta <= '0;
      q_out <= '0;
    end
    else
    begin
      meta <= d_in;
      q_out <= meta;
    end
  end

endmodule // isrt_sync

// ===== tb/isrt_host_asserts.sv
// port checker for the stop and restart controller
`timescale 1ns/1ns
module isrt_host_asserts
  import isrt_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic irq_out,
  input wire logic dev_wr_out,
  input wire logic dev_master_select_out,
  input wire logic dev_transmit_select_out,
  input wire logic dev_service_request_out,
  input wire logic dev_bus_busy_out,
  input wire logic dev_bus_busy_in,
  input wire logic dev_last_received_bit_in,
  input wire logic clock_line_pin_in,
  input wire logic data_line_pin_in,
  input wire logic clock_line_pin_out,
  input wire logic clock_line_pin_oe_out
);
  logic [7:0] lrb_cnt;
  logic [7:0] free_cnt;
  logic ctrl_wr;
  logic lrb_ok;
  logic free_ok;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // ************
  // helpers
  // ************
  // raw inputs are counted, so the sync lag only adds margin
  assign ctrl_wr = psel && penable && pwrite && paddr == REG_CTRL;
  assign lrb_ok = dev_last_received_bit_in && !dev_bus_busy_in;
  assign free_ok = clock_line_pin_in && data_line_pin_in;
  // run lengths of a set last bit with busy low and a free bus, saturating
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in || !lrb_ok)
      lrb_cnt <= 8'h00;
    else
      lrb_cnt <= lrb_cnt + {7'h00, lrb_cnt != 8'hFF};
    if (!resetn_in || !free_ok)
      free_cnt <= 8'h00;
    else
      free_cnt <= free_cnt + {7'h00, free_cnt != 8'hFF};
  end
  // ************
  // assertions
  // ************
  AST_WR_CAUSE: assert property (
    dev_wr_out |-> $past(ctrl_wr)) else $error("strobe without write");
  AST_STOP_WORD: assert property (
    dev_wr_out && dev_master_select_out |-> dev_transmit_select_out
    && dev_service_request_out && !dev_bus_busy_out)
    else $error("bad stop word");
  AST_STOP_BUSY: assert property (
    dev_wr_out && dev_master_select_out |-> $past(dev_bus_busy_in, 3))
    else $error("stop asked on idle bus");
  AST_RESTART_WORD: assert property (
    dev_wr_out && !dev_master_select_out |-> !dev_transmit_select_out
    && !dev_bus_busy_out && dev_service_request_out)
    else $error("bad restart word");
  AST_WORD_HOLD: assert property (
    !dev_wr_out |-> $stable({dev_master_select_out, dev_transmit_select_out,
    dev_service_request_out, dev_bus_busy_out}))
    else $error("word changed without strobe");
  AST_STRETCH_MIN: assert property (
    $rose(clock_line_pin_oe_out) |-> clock_line_pin_oe_out [*5])
    else $error("stretch too short");
  AST_PULL_LOW: assert property (
    clock_line_pin_oe_out |-> !clock_line_pin_out)
    else $error("clock line driven high");
  AST_RESTART_FREE: assert property (
    $rose(irq_out) && !dev_master_select_out && dev_service_request_out
    |-> lrb_cnt >= 8'h0C) else $error("restart ready too soon");
  AST_STOP_FREE: assert property (
    $rose(irq_out) && dev_master_select_out |-> free_cnt >= 8'h1A)
    else $error("bus free time too short");
endmodule // isrt_host_asserts

bind isrt_host isrt_host_asserts u_chk (.ref_clk_in, .resetn_in, .psel,
  .penable, .pwrite, .paddr, .irq_out, .dev_wr_out, .dev_master_select_out,
  .dev_transmit_select_out, .dev_service_request_out, .dev_bus_busy_out,
  .dev_bus_busy_in, .dev_last_received_bit_in, .clock_line_pin_in,
  .data_line_pin_in, .clock_line_pin_out, .clock_line_pin_oe_out);

// ===== tb/isrt_dev_model.sv
// behavioural model of the serial bus unit behind the controller
`timescale 1ns/1ns
module isrt_dev_model #(
  parameter int M = 6,
  parameter int N = 4
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic rebusy_in,
  input wire logic wr_in,
  input wire logic mst_in,
  input wire logic trx_in,
  input wire logic pin_in,
  input wire logic bb_in,
  input wire logic scl_in,
  input wire logic nack_in,
  output logic busy_out,
  output logic lrb_out,
  output logic scl_low_out,
  output logic sda_out
);
  int cnt;
  logic [1:0] st;
  logic stop;
  // ************
  // sequencing
  // ************
  // last bit: clock line, or stuck at one after a nack
  assign lrb_out = scl_in || nack_in;
  // starts mid-transfer: busy, clock and data held low
  always_ff @(posedge ref_clk_in)
  begin
    cnt <= cnt + 1;
    if (!resetn_in || rebusy_in)
    begin
      st <= 2'h0;
      busy_out <= 1'b1;
      scl_low_out <= 1'b1;
      sda_out <= 1'b0;
      stop <= 1'b0;
    end
    // word taken, data high only on restart
    else if (st == 2'h0 && wr_in && pin_in)
    begin
      st <= 2'h1;
      stop <= mst_in && trx_in && !bb_in;
      sda_out <= !(mst_in && trx_in);
      cnt <= 0;
    end
    // clock released n cycles after request
    else if (st == 2'h1 && cnt >= N)
    begin
      scl_low_out <= 1'b0;
      st <= 2'h2;
      cnt <= 0;
    end
    // own clock released, busy drops, no stop made
    else if (st == 2'h2 && !stop)
    begin
      busy_out <= 1'b0;
      st <= 2'h3;
    end
    // another device still holds the clock
    else if (st == 2'h2 && !scl_in)
      cnt <= 0;
    else if (st == 2'h2 && cnt >= M)
    begin
      sda_out <= 1'b1;
      busy_out <= 1'b0;
      st <= 2'h3;
    end
  end
endmodule // isrt_dev_model

// ===== tb/isrt_host_tb.sv
// self-checking bench for the stop and restart controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module isrt_host_tb
  import isrt_pkg::*;
;
  logic ref_clk_in = 1'b0, resetn_in = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, hold = 1'b0, rebusy = 1'b0, nack = 1'b0, scl_low;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, e;
  logic pready, pslverr, irq_out, dev_wr_out, dev_master_select_out;
  logic dev_transmit_select_out, dev_service_request_out, dev_bus_busy_out;
  logic dev_bus_busy_in, dev_last_received_bit_in, data_line_pin_in;
  logic clock_line_pin_in, clock_line_pin_out, clock_line_pin_oe_out;
  int error_cnt = 0, checked = 0, cyc = 0, n, k, r;
  logic [31:0] exp_q[$];
  // open-drain clock line with pull-up
  assign clock_line_pin_in = !(clock_line_pin_oe_out && !clock_line_pin_out)
    && !scl_low && !hold;
  isrt_host DUT (.ref_clk_in, .resetn_in, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq_out, .dev_wr_out,
    .dev_master_select_out, .dev_transmit_select_out,
    .dev_service_request_out, .dev_bus_busy_out, .dev_bus_busy_in,
    .dev_last_received_bit_in, .clock_line_pin_in, .data_line_pin_in,
    .clock_line_pin_out, .clock_line_pin_oe_out);
  isrt_dev_model u_dev (.ref_clk_in, .resetn_in, .rebusy_in(rebusy),
    .wr_in(dev_wr_out), .mst_in(dev_master_select_out),
    .trx_in(dev_transmit_select_out), .pin_in(dev_service_request_out),
    .bb_in(dev_bus_busy_out), .scl_in(clock_line_pin_in), .nack_in(nack),
    .busy_out(dev_bus_busy_in), .lrb_out(dev_last_received_bit_in),
    .scl_low_out(scl_low), .sda_out(data_line_pin_in));
  // ************
  // clock, timeout, monitor
  // ************
  always #25 ref_clk_in = ~ref_clk_in;
  // a hang ends the run as a failure
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done;
    end
  end
  // each read answer is matched with the oldest note
  always @(posedge ref_clk_in)
    if (psel && penable && pready && !pwrite)
    begin
      e = exp_q.pop_front();
      `CHK("prdata", e, prdata)
      `CHK("pslverr", paddr > REG_STRETCH_LEN, pslverr)
    end
  // ************
  // tasks
  // ************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    @(posedge ref_clk_in);
    while (pready !== 1'b1) @(posedge ref_clk_in);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask
  // waits, bounded, for the interrupt line
  task automatic wait_irq(output int c);
    c = 0;
    while (irq_out !== 1'b1 && c < 3000)
    begin
      @(negedge ref_clk_in);
      c++;
    end
    // a missing interrupt is a mismatch, not just a long wait
    if (c >= 3000)
      error_cnt++;
  endtask
  task automatic test_done;
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ************
  // main sequence
  // ************
  initial
  begin
    r = $urandom(32'h3EEC);
    repeat (12) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    rd(REG_INT_MASK, 32'h0);
    rd(REG_STRETCH_LEN, 32'h5);
    rd(8'h14, 32'h0);
    apb(1'b1, REG_INT_MASK, 32'h3);
    // another device holds the clock while a stop is asked
    hold <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (40) @(posedge ref_clk_in);
    `CHK("sda held", 1'b0, data_line_pin_in)
    hold <= 1'b0;
    wait_irq(n);
    `CHK("sda stop", 1'b1, data_line_pin_in)
    `CHK("busy", 1'b0, dev_bus_busy_in)
    `CHK("bus free", 1'b1, n >= 94)
    rd(REG_INT_STATUS, 32'h1);
    @(negedge ref_clk_in);
    `CHK("irq clear", 1'b0, irq_out)
    // stop on an idle bus is refused, and its event is masked
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (2) @(negedge ref_clk_in);
    `CHK("no strobe", 1'b0, dev_wr_out)
    `CHK("masked", 1'b0, irq_out)
    rd(REG_INT_STATUS, 32'h4);
    // restart in standard, fast and receiver modes
    for (int f = 0; f < 3; f++)
    begin
      rebusy <= 1'b1;
      // receiver mode ends on a nack, so the last bit cannot show the clock
      nack <= (f == 2);
      @(posedge ref_clk_in);
      rebusy <= 1'b0;
      hold <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      apb(1'b1, REG_CTRL, f == 0 ? 32'h2 : (f == 1 ? 32'h6 : 32'hE));
      repeat (30) @(posedge ref_clk_in);
      `CHK("held clock", 1'b0, irq_out)
      hold <= 1'b0;
      wait_irq(n);
      `CHK("setup wait", 1'b1, n >= (f == 0 ? 94 : 12))
      rd(REG_INT_STATUS, 32'h2);
    end
    rd(REG_STATUS, 32'h7);
    // stretch with random lengths, never below five cycles
    repeat (3)
    begin
      r = $urandom_range(8, 1);
      apb(1'b1, REG_STRETCH_LEN, r);
      rd(REG_STRETCH_LEN, r);
      apb(1'b1, REG_CTRL, 32'h10);
      k = 0;
      // sampled on the falling edge, where the enable has settled
      while (clock_line_pin_oe_out !== 1'b1 && k < 20)
      begin
        @(negedge ref_clk_in);
        k++;
      end
      n = 0;
      while (clock_line_pin_oe_out === 1'b1 && n < 300)
      begin
        @(negedge ref_clk_in);
        n++;
      end
      `CHK("stretch", (r > 5) ? r : 5, n)
    end
    test_done;
  end
endmodule // isrt_host_tb
